/* sdram_mode_register_file.sv */
// mode register file of the sdram: register access, status and burst ordering
// assumes command decode delivers one-cycle strobes synchronous to mclk
`include "mode_reg_consts.svh"
// What this block does
// - each register is readable, writable or both; access honours that class
// - only register read and register write commands access the registers
// - reserved bits read back as zero
// - read of reserved or write-only register still answers with strobe, data undefined
// - write to a read-only register changes nothing
// - device information bit 0 is one while auto-init runs, zero after
// - device type bit and invalid data support bit both read zero
// - self-test field: 00 not run, 01 tied high, 10 shorted, 11 good
// - self-test field updates only when init calibration completes
// - pin tied to command bus supply makes self-test field read 01
// - result 01 or 10 selects factory trim and drops calibration commands
// - burst length field 010/011/100 gives 4/8/16, default 4
// - burst type bit: zero sequential default, one interleaved
// - wrap bit: zero wrap default, one no-wrap legal only with 4 beats
// - write recovery codes 001 to 110 give 3 to 8, default 3
// - beats follow programmed order; interleave only for 8 beats
// - column bit 0 forced zero; order uses 2, 3 or 4 low bits
// - latency codes 0001 to 0110 select read/write pairs, default 3/1
// - drive strength codes select impedance, default 40 ohm
// - auto-init completes within 10 us after the reset write
// - reading refresh status clears the temperature update flag
module sdram_mode_register_file
	import mode_reg_pkg::*;
#(
	parameter logic [7:0] MAKER_CODE = 8'h5a, // arbitrary value
	parameter logic [7:0] REV_ONE_CODE = 8'h11, // arbitrary value
	parameter logic [7:0] REV_TWO_CODE = 8'h22, // arbitrary value
	parameter logic [7:0] GEOMETRY_CODE = 8'h48,
	parameter logic [7:0] PATTERN_A = 8'h55,
	parameter logic [7:0] PATTERN_B = 8'h33
) (
	// clock and reset
	input wire logic mclk,
	input wire logic rst_b,
	// register command port
	input wire logic regReadStrobe,
	input wire logic regWriteStrobe,
	input wire logic [7:0] register_address,
	input wire logic [7:0] register_operand,
	// read answer
	output logic readValid,
	output logic [7:0] readData,
	// status from core engines
	input wire logic initCalDone,
	input wire logic [1:0] selfTestIn,
	input wire logic pinTiedToSupply,
	input wire logic [2:0] refreshRateIn,
	// calibration command out
	output logic calCmdValid,
	output logic [7:0] calCmdCode,
	output logic useFactoryTrim,
	// configuration out
	output mode_cfg_t cfg,
	output logic [3:0] read_latency,
	output logic [2:0] write_latency,
	output logic [3:0] writeRecoveryClocks,
	output logic autoInitBusy,
	// burst column ordering
	input wire logic burstStart,
	input wire logic [3:0] startColumn,
	output logic burstActive,
	output logic [3:0] beatColumn
);
	// --------------------------------------------------------------
	// decode
	// --------------------------------------------------------------
	logic wrBurst, wrLat, wrDrive, wrCal, wrMask, wrReset, rdRefresh;
	logic [1:0] zq_selftest_result;
	logic [2:0] refreshRate;
	logic temperature_update_flag;
	init_state_t initState;
	logic [10:0] initCount;
	logic [4:0] beatCount;
	logic [4:0] beatTotal;
	logic [3:0] beatStart;
	logic [3:0] beatStep;

	// only the two command strobes reach the registers
	assign wrBurst = regWriteStrobe && register_address == `ADDR_BURST_CFG;
	assign wrLat = regWriteStrobe && register_address == `ADDR_LATENCY_CFG;
	assign wrDrive = regWriteStrobe && register_address == `ADDR_DRIVE_CFG;
	assign wrCal = regWriteStrobe && register_address == `ADDR_CAL_CMD;
	assign wrMask = regWriteStrobe && register_address == `ADDR_BANK_MASK;
	assign wrReset = regWriteStrobe && register_address == `ADDR_SOFT_RESET;
	assign rdRefresh = regReadStrobe && register_address == `ADDR_REFRESH_STAT;

	// --------------------------------------------------------------
	// writable configuration
	// --------------------------------------------------------------
	// reserved codes leave the field alone; read-only addresses decode to nothing
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			cfg.burst_length_field <= `BL_4;
			cfg.burst_type_bit <= 1'b0;
			cfg.wrap_control_bit <= 1'b0;
			cfg.write_recovery_count <= `WR_MIN_CODE;
		end else if (wrReset) begin
			cfg.burst_length_field <= `BL_4;
			cfg.burst_type_bit <= 1'b0;
			cfg.wrap_control_bit <= 1'b0;
			cfg.write_recovery_count <= `WR_MIN_CODE;
		end else if (wrBurst) begin
			if (register_operand[2:0] >= `BL_4 && register_operand[2:0] <= `BL_16) begin
				cfg.burst_length_field <= register_operand[2:0];
				// no-wrap only taken with 4 beats
				cfg.wrap_control_bit <= register_operand[4] && register_operand[2:0] == `BL_4;
			end
			cfg.burst_type_bit <= register_operand[3];
			if (register_operand[7:5] >= `WR_MIN_CODE && register_operand[7:5] <= `WR_MAX_CODE) begin
				cfg.write_recovery_count <= register_operand[7:5];
			end
		end
	end

	// latency, drive strength and bank mask
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			cfg.latencyCode <= `LAT_DEFAULT;
			cfg.drive_strength_field <= `DS_DEFAULT;
			cfg.bankMask <= 4'h0;
		end else if (wrReset) begin
			cfg.latencyCode <= `LAT_DEFAULT;
			cfg.drive_strength_field <= `DS_DEFAULT;
			cfg.bankMask <= 4'h0;
		end else begin
			if (wrLat && register_operand[3:0] != 4'h0 && register_operand[3:0] <= `LAT_MAX_CODE) begin
				cfg.latencyCode <= register_operand[3:0];
			end
			if (wrDrive && register_operand[3:0] != 4'h0 && register_operand[3:0] <= 4'h7
					&& register_operand[3:0] != 4'h5) begin
				cfg.drive_strength_field <= register_operand[3:0];
			end
			if (wrMask) begin
				cfg.bankMask <= register_operand[3:0]; // upper bits ignored
			end
		end
	end

	// decoded counts for the core timing engines
	always_comb begin
		read_latency = cfg.latencyCode + 4'h2;
		case (cfg.latencyCode)
			4'h1: write_latency = 3'h1;
			4'h2, 4'h3: write_latency = 3'h2;
			4'h4: write_latency = 3'h3;
			default: write_latency = 3'h4;
		endcase
		writeRecoveryClocks = {1'b0, cfg.write_recovery_count} + 4'h2;
	end

	// --------------------------------------------------------------
	// auto-initialization status
	// --------------------------------------------------------------
	// restarted by power-on reset and by the soft reset write
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			initState <= INIT_BUSY;
			initCount <= 11'h0;
		end else if (wrReset) begin
			initState <= INIT_BUSY;
			initCount <= 11'h0;
		end else if (initState == INIT_BUSY) begin
			initCount <= initCount + 11'h1;
			if (initCount == 11'(`INIT_CYCLES - 1)) begin
				initState <= INIT_DONE;
			end
		end
	end
	assign autoInitBusy = initState == INIT_BUSY;

	// self-test result, only on init calibration completion
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			zq_selftest_result <= `ZQ_NOT_RUN;
		end else if (initCalDone) begin
			zq_selftest_result <= pinTiedToSupply ? `ZQ_TIED_HIGH : selfTestIn;
		end
	end

	// a suspect pin falls back to factory trim
	assign useFactoryTrim = zq_selftest_result == `ZQ_TIED_HIGH || zq_selftest_result == `ZQ_SHORTED;

	// forward valid calibration codes; reserved codes and factory trim drop them
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			calCmdValid <= 1'b0;
			calCmdCode <= 8'h00;
		end else begin
			calCmdValid <= wrCal && !useFactoryTrim && (register_operand == `CAL_INIT
				|| register_operand == `CAL_LONG || register_operand == `CAL_SHORT
				|| register_operand == `CAL_RESET);
			if (wrCal) begin
				calCmdCode <= register_operand;
			end
		end
	end

	// --------------------------------------------------------------
	// refresh rate and temperature update flag
	// --------------------------------------------------------------
	// a change in the same cycle as the read keeps the flag set
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			refreshRate <= 3'h3;
			temperature_update_flag <= 1'b0;
		end else begin
			refreshRate <= refreshRateIn;
			if (refreshRateIn != refreshRate) begin
				temperature_update_flag <= 1'b1;
			end else if (rdRefresh) begin
				temperature_update_flag <= 1'b0;
			end
		end
	end

	// --------------------------------------------------------------
	// read path
	// --------------------------------------------------------------
	// every read answers one cycle later, even for unreadable addresses
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			readValid <= 1'b0;
			readData <= 8'h00;
		end else begin
			readValid <= regReadStrobe;
			if (regReadStrobe) begin
				case (register_address)
					`ADDR_DEVICE_INFO: readData <= {3'h0, zq_selftest_result, 2'h0, autoInitBusy};
					`ADDR_REFRESH_STAT: readData <= {temperature_update_flag, 4'h0, refreshRate};
					`ADDR_MAKER_ID: readData <= MAKER_CODE;
					`ADDR_REV_ONE: readData <= REV_ONE_CODE;
					`ADDR_REV_TWO: readData <= REV_TWO_CODE;
					`ADDR_GEOMETRY: readData <= GEOMETRY_CODE;
					`ADDR_TRAIN_A: readData <= PATTERN_A;
					`ADDR_TRAIN_B: readData <= PATTERN_B;
					default: readData <= 8'h00; // undefined data; zero is as good as any
				endcase
			end
		end
	end

	// --------------------------------------------------------------
	// burst column order
	// --------------------------------------------------------------
	// column bit 0 is never carried, so it is forced low
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			beatCount <= 5'h0;
			beatStart <= 4'h0;
		end else if (burstStart) begin
			beatCount <= 5'h1;
			beatStart <= {startColumn[3:1], 1'b0};
		end else if (beatCount != 5'h0 && beatCount != beatTotal) begin
			beatCount <= beatCount + 5'h1;
		end else begin
			beatCount <= 5'h0;
		end
	end

	assign beatTotal = cfg.burst_length_field == `BL_16 ? 5'h10 :
		cfg.burst_length_field == `BL_8 ? 5'h08 : 5'h04;
	assign burstActive = beatCount != 5'h0;
	assign beatStep = beatCount[3:0] - 4'h1;

	// sequential wraps within the burst except with no-wrap, interleave xors for 8 beats
	always_comb begin
		if (!burstActive) begin
			beatColumn = 4'h0;
		end else if (cfg.burst_length_field == `BL_8 && cfg.burst_type_bit) begin
			beatColumn = {1'b0, beatStart[2:0] ^ beatStep[2:0]};
		end else if (cfg.burst_length_field == `BL_8) begin
			beatColumn = {1'b0, beatStart[2:0] + beatStep[2:0]};
		end else if (cfg.burst_length_field == `BL_16) begin
			beatColumn = beatStart + beatStep;
		end else if (cfg.wrap_control_bit) begin
			beatColumn = beatStart + beatStep; // no wrap; boundaries kept by the controller
		end else begin
			beatColumn = {2'h0, beatStart[1:0] + beatStep[1:0]};
		end
	end

	// --------------------------------------------------------------
	// checks
	// --------------------------------------------------------------
	logic [11:0] busyCycles;
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			busyCycles <= 12'h0;
		end else if (wrReset || !autoInitBusy) begin
			busyCycles <= 12'h0;
		end else begin
			busyCycles <= busyCycles + 12'h1;
		end
	end

	a_init_time_bound: assert property (@(posedge mclk) disable iff (!rst_b)
		busyCycles <= 12'(`INIT_CYCLES)) else $error("auto-init exceeded its time");
	a_read_always_answers: assert property (@(posedge mclk) disable iff (!rst_b)
		regReadStrobe |=> readValid) else $error("read without answer");
	a_info_reserved_zero: assert property (@(posedge mclk) disable iff (!rst_b)
		regReadStrobe && register_address == `ADDR_DEVICE_INFO |=> readData[7:5] == 3'h0 && readData[2:1] == 2'h0
		&& readData[0] == $past(autoInitBusy)) else $error("device info bits wrong");
	a_tuf_read_clear: assert property (@(posedge mclk) disable iff (!rst_b)
		rdRefresh && refreshRateIn == refreshRate |=> !temperature_update_flag) else $error("flag not cleared");
	a_ro_write_ignored: assert property (@(posedge mclk) disable iff (!rst_b)
		regWriteStrobe && register_address == `ADDR_DEVICE_INFO |=> $stable(cfg)) else $error("read-only write acted");
	a_selftest_hold: assert property (@(posedge mclk) disable iff (!rst_b)
		!initCalDone |=> $stable(zq_selftest_result)) else $error("self-test moved early");
	a_tied_reads_one: assert property (@(posedge mclk) disable iff (!rst_b)
		initCalDone && pinTiedToSupply |=> zq_selftest_result == `ZQ_TIED_HIGH) else $error("tied pin not 01");
	a_trim_blocks_cal: assert property (@(posedge mclk) disable iff (!rst_b)
		useFactoryTrim && !initCalDone |=> !calCmdValid) else $error("calibration passed under trim");
	a_nowrap_only_bl4: assert property (@(posedge mclk) disable iff (!rst_b)
		cfg.wrap_control_bit |-> cfg.burst_length_field == `BL_4) else $error("no-wrap with long burst");
	a_burst_length_beats: assert property (@(posedge mclk) disable iff (!rst_b)
		burstStart && cfg.burst_length_field == `BL_4 && !wrBurst |=> burstActive [*4] ##1 !burstActive || burstStart)
		else $error("burst of 4 wrong length");
	// reserved codes must leave each field exactly as it was
	a_burst_code_keep: assert property (@(posedge mclk) disable iff (!rst_b)
		wrBurst && (register_operand[2:0] < `BL_4 || register_operand[2:0] > `BL_16)
		|=> $stable(cfg.burst_length_field)) else $error("reserved burst length taken");
	a_recovery_code_keep: assert property (@(posedge mclk) disable iff (!rst_b)
		wrBurst && (register_operand[7:5] < `WR_MIN_CODE || register_operand[7:5] > `WR_MAX_CODE)
		|=> $stable(cfg.write_recovery_count)) else $error("reserved recovery code taken");
	a_latency_code_keep: assert property (@(posedge mclk) disable iff (!rst_b)
		wrLat && (register_operand[3:0] == 4'h0 || register_operand[3:0] > `LAT_MAX_CODE)
		|=> $stable(cfg.latencyCode)) else $error("reserved latency code taken");
	a_drive_code_keep: assert property (@(posedge mclk) disable iff (!rst_b)
		wrDrive && (register_operand[3:0] == 4'h0 || register_operand[3:0] == 4'h5 || register_operand[3:0] > 4'h7)
		|=> $stable(cfg.drive_strength_field)) else $error("reserved drive code taken");
	a_reset_write_busy: assert property (@(posedge mclk) disable iff (!rst_b)
		wrReset |=> autoInitBusy && cfg.burst_length_field == `BL_4) else $error("soft reset did not restart");
	a_selftest_latch: assert property (@(posedge mclk) disable iff (!rst_b)
		initCalDone && !pinTiedToSupply |=> zq_selftest_result == $past(selfTestIn)) else $error("self-test not latched");
	a_tuf_change_sets: assert property (@(posedge mclk) disable iff (!rst_b)
		refreshRateIn != refreshRate |=> temperature_update_flag) else $error("rate change did not set flag");
	a_first_beat_even: assert property (@(posedge mclk) disable iff (!rst_b)
		burstStart |=> burstActive && !beatColumn[0]) else $error("first beat on odd column");
endmodule : sdram_mode_register_file

/* mode_reg_consts.svh */
// mode register file constants: addresses, field codes, defaults, timing
// assumes inclusion by the package, the design module and the bench top only
`ifndef MODE_REG_CONSTS_SVH
`define MODE_REG_CONSTS_SVH
// --------------------------------------------------------------
// register addresses
// --------------------------------------------------------------
`define ADDR_DEVICE_INFO 8'h00
`define ADDR_BURST_CFG 8'h01
`define ADDR_LATENCY_CFG 8'h02
`define ADDR_DRIVE_CFG 8'h03
`define ADDR_REFRESH_STAT 8'h04
`define ADDR_MAKER_ID 8'h05
`define ADDR_REV_ONE 8'h06
`define ADDR_REV_TWO 8'h07
`define ADDR_GEOMETRY 8'h08
`define ADDR_TEST_MODE 8'h09
`define ADDR_CAL_CMD 8'h0a
`define ADDR_BANK_MASK 8'h10
`define ADDR_TRAIN_A 8'h20
`define ADDR_TRAIN_B 8'h28
`define ADDR_SOFT_RESET 8'h3f
// --------------------------------------------------------------
// field codes and defaults
// --------------------------------------------------------------
`define BL_4 3'h2
`define BL_8 3'h3
`define BL_16 3'h4
`define WR_MIN_CODE 3'h1
`define WR_MAX_CODE 3'h6
`define LAT_DEFAULT 4'h1
`define LAT_MAX_CODE 4'h6
`define DS_DEFAULT 4'h2
`define ZQ_NOT_RUN 2'h0
`define ZQ_TIED_HIGH 2'h1
`define ZQ_SHORTED 2'h2
`define CAL_INIT 8'hff
`define CAL_LONG 8'hab
`define CAL_SHORT 8'h56
`define CAL_RESET 8'hc3
// --------------------------------------------------------------
// timing
// --------------------------------------------------------------
`define CLK_PERIOD_PS 8000
`define INIT_TIME_US 10
// longest time: round down
`define INIT_CYCLES ((`INIT_TIME_US * 1000000) / `CLK_PERIOD_PS)
`endif

/* mode_reg_pkg.sv */
// types shared by the mode register file
// assumes mode_reg_consts.svh on the include path
package mode_reg_pkg;
	`include "mode_reg_consts.svh"
	typedef struct packed {
		logic [2:0] burst_length_field;
		logic burst_type_bit;
		logic wrap_control_bit;
		logic [2:0] write_recovery_count;
		logic [3:0] latencyCode;
		logic [3:0] drive_strength_field;
		logic [3:0] bankMask;
	} mode_cfg_t;
	typedef enum logic [0:0] {
		INIT_BUSY = 1'b1,
		INIT_DONE = 1'b0
	} init_state_t;
endpackage : mode_reg_pkg

/* mode_ctrl_model.sv */
// controller model: issues register reads, register writes and burst starts
// assumes the bench calls its tasks from one process, off the sampling edge
module mode_ctrl_model (
	// clock
	input wire logic mclk,
	// command side
	output logic regReadStrobe,
	output logic regWriteStrobe,
	output logic [7:0] register_address,
	output logic [7:0] register_operand,
	output logic burstStart,
	output logic [3:0] startColumn,
	// answer side
	input wire logic readValid,
	input wire logic [7:0] readData
);
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------------------------------------------------
	// idle levels
	// ----------------------------------------------------------
	initial begin
		regReadStrobe = 1'b0;
		regWriteStrobe = 1'b0;
		register_address = 8'h00;
		register_operand = 8'h00;
		burstStart = 1'b0;
		startColumn = 4'h0;
	end
	// ----------------------------------------------------------
	// command tasks
	// ----------------------------------------------------------
	// write; reserved operand bits go out as zero, reserved addresses never
	task automatic wr(input logic [7:0] a, input logic [7:0] op, output logic [7:0] sent);
		sent = (a == 8'h02 || a == 8'h03 || a == 8'h10) ? op & 8'h0f : op;
		if (a == 8'h01 && sent[2:0] != 3'h2)
			sent[4] = 1'b0; // no-wrap only with 4 beats
		if (a == 8'h11 || (a > 8'h0a && a < 8'h10) || a > 8'h3f)
			return;
		@(posedge mclk);
		regWriteStrobe <= 1'b1;
		register_address <= a;
		register_operand <= sent;
		@(posedge mclk);
		regWriteStrobe <= 1'b0;
		register_address <= ~a; // released lines show no stale value
		register_operand <= ~sent;
	endtask : wr
	// read; lat counts cycles from the taking edge to the answer
	task automatic rd(input logic [7:0] a, output logic [7:0] d, output int lat);
		@(posedge mclk);
		regReadStrobe <= 1'b1;
		register_address <= a;
		@(posedge mclk);
		regReadStrobe <= 1'b0;
		register_address <= ~a;
		lat = 0;
		do begin
			@(negedge mclk);
			lat++;
		end while (readValid !== 1'b1 && lat < 4);
		d = readData;
	endtask : rd
	// burst start; no-wrap runs are kept off the page edge
	task automatic burst(input logic [3:0] col, input logic nowrap, output logic [3:0] used);
		used = (nowrap && col[3:1] == 3'h7) ? 4'h4 : col;
		@(posedge mclk);
		burstStart <= 1'b1;
		startColumn <= used;
		@(posedge mclk);
		burstStart <= 1'b0;
		startColumn <= ~used;
	endtask : burst
endmodule : mode_ctrl_model

/* sdram_mode_register_file_tb_top.sv */
// self-checking bench for the mode register file
// assumes mode_reg_pkg and mode_ctrl_model compiled before it
`include "mode_reg_consts.svh"
module sdram_mode_register_file_tb_top
	import mode_reg_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------------------------------------------------
	// signals and tables
	// ----------------------------------------------------------
	localparam logic [7:0] MAKER = 8'h3c; // arbitrary value
	localparam logic [7:0] REV1 = 8'h61; // arbitrary value
	localparam logic [7:0] REV2 = 8'h62; // arbitrary value
	logic mclk, rst_b, regReadStrobe, regWriteStrobe, readValid, initCalDone, pinTiedToSupply;
	logic calCmdValid, useFactoryTrim, autoInitBusy, burstStart, burstActive;
	logic [7:0] register_address, register_operand, readData, calCmdCode, d, sent, a;
	logic [1:0] selfTestIn, zq;
	logic [2:0] refreshRateIn, write_latency;
	logic [3:0] read_latency, writeRecoveryClocks, startColumn, beatColumn, col, msk;
	mode_cfg_t cfg, expCfg;
	mode_cfg_t defCfg = '{`BL_4, 1'b0, 1'b0, `WR_MIN_CODE, `LAT_DEFAULT, `DS_DEFAULT, 4'h0};
	int mismatches, nTests, seed, lat, n, len;
	logic [7:0] roAddr [6] = '{8'h05, 8'h06, 8'h07, 8'h08, 8'h20, 8'h28};
	logic [7:0] roVal [6] = '{MAKER, REV1, REV2, 8'h48, 8'h55, 8'h33};
	logic [7:0] woAddr [8] = '{8'h01, 8'h02, 8'h03, 8'h09, 8'h0a, 8'h10, 8'h11, 8'h0b};
	logic [7:0] wrAddr [6] = '{8'h01, 8'h02, 8'h03, 8'h10, 8'h00, 8'h05};
	logic [7:0] calCode [5] = '{`CAL_INIT, `CAL_LONG, `CAL_SHORT, `CAL_RESET, 8'h12};
	logic [4:0] bMode [6] = '{5'h02, 5'h0a, 5'h12, 5'h03, 5'h0b, 5'h04};

	sdram_mode_register_file #(.MAKER_CODE(MAKER), .REV_ONE_CODE(REV1), .REV_TWO_CODE(REV2)) u_dut (
		.mclk(mclk), .rst_b(rst_b), .regReadStrobe(regReadStrobe), .regWriteStrobe(regWriteStrobe),
		.register_address(register_address), .register_operand(register_operand), .readValid(readValid),
		.readData(readData), .initCalDone(initCalDone), .selfTestIn(selfTestIn),
		.pinTiedToSupply(pinTiedToSupply), .refreshRateIn(refreshRateIn), .calCmdValid(calCmdValid),
		.calCmdCode(calCmdCode), .useFactoryTrim(useFactoryTrim), .cfg(cfg), .read_latency(read_latency),
		.write_latency(write_latency), .writeRecoveryClocks(writeRecoveryClocks),
		.autoInitBusy(autoInitBusy), .burstStart(burstStart), .startColumn(startColumn),
		.burstActive(burstActive), .beatColumn(beatColumn));
	mode_ctrl_model u_ctl (
		.mclk(mclk), .regReadStrobe(regReadStrobe), .regWriteStrobe(regWriteStrobe),
		.register_address(register_address), .register_operand(register_operand),
		.burstStart(burstStart), .startColumn(startColumn), .readValid(readValid), .readData(readData));
	// ----------------------------------------------------------
	// helpers
	// ----------------------------------------------------------
	function automatic logic [2:0] wl_of(input logic [3:0] c);
		return (c < 4'h2) ? 3'h1 : (c < 4'h4) ? 3'h2 : (c == 4'h4) ? 3'h3 : 3'h4;
	endfunction : wl_of
	// column bit 0 is dropped before ordering
	function automatic logic [3:0] beat(input mode_cfg_t c, input logic [3:0] s, input int i);
		if (c.burst_length_field == `BL_8 && c.burst_type_bit)
			return {s[3:1], 1'b0} ^ 4'(i);
		return {s[3:1], 1'b0} + 4'(i);
	endfunction : beat
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		nTests++;
		if (seen !== exp) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", nTests, mismatches);
		if (mismatches == 0 && nTests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : wrap_up
	task automatic model_write(input logic [7:0] wa, input logic [7:0] o);
		case (wa)
			8'h01: begin
				// a reserved length code leaves length and wrap bit alone
				if (o[2:0] inside {`BL_4, `BL_8, `BL_16}) begin
					expCfg.burst_length_field = o[2:0];
					expCfg.wrap_control_bit = o[4] && o[2:0] == `BL_4;
				end
				expCfg.burst_type_bit = o[3];
				if (o[7:5] inside {[`WR_MIN_CODE:`WR_MAX_CODE]}) expCfg.write_recovery_count = o[7:5];
			end
			8'h02: if (o[3:0] inside {[`LAT_DEFAULT:`LAT_MAX_CODE]}) expCfg.latencyCode = o[3:0];
			8'h03: if (o[3:0] inside {4'h1, 4'h2, 4'h3, 4'h4, 4'h6, 4'h7}) expCfg.drive_strength_field = o[3:0];
			8'h10: expCfg.bankMask = o[3:0];
			8'h3f: expCfg = defCfg;
			default: ; // read-only targets leave everything alone
		endcase
	endtask : model_write
	task automatic cmp_cfg;
		check("cfg", cfg, expCfg);
		check("rl", read_latency, expCfg.latencyCode + 4'h2);
		check("wl", write_latency, wl_of(expCfg.latencyCode));
		check("nwr", writeRecoveryClocks, expCfg.write_recovery_count + 4'h2);
	endtask : cmp_cfg
	// bounded wait for auto-init to end
	task automatic wait_init;
		n = 0;
		while (autoInitBusy !== 1'b0 && n < 1400) begin
			@(negedge mclk);
			n++;
		end
		if (n >= 1400) begin
			mismatches++;
			wrap_up();
		end
	endtask : wait_init
	// ----------------------------------------------------------
	// clock and main sequence
	// ----------------------------------------------------------
	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end
	initial begin
		mismatches = 0;
		nTests = 0;
		seed = 32'hf53cfe5e;
		rst_b = 1'b0;
		initCalDone = 1'b0;
		selfTestIn = 2'h0;
		pinTiedToSupply = 1'b0;
		refreshRateIn = 3'h3;
		expCfg = defCfg;
		zq = 2'h0;
		repeat (16) @(posedge mclk);
		rst_b <= 1'b1;
		@(negedge mclk);
		cmp_cfg();
		wait_init();
		u_ctl.rd(8'h00, d, lat);
		check("devinfo", d, 8'h00);
		// self-test results, last pass with the pin tied to the supply
		for (int v = 0; v < 5; v++) begin
			@(posedge mclk);
			selfTestIn <= 2'(v % 4);
			pinTiedToSupply <= (v == 4);
			u_ctl.rd(8'h00, d, lat);
			if (v < 4)
				check("held", d[4:3], zq);
			@(posedge mclk);
			initCalDone <= 1'b1;
			@(posedge mclk);
			initCalDone <= 1'b0;
			zq = (v == 4) ? 2'h1 : 2'(v);
			u_ctl.rd(8'h00, d, lat);
			check("selftest", d, {3'h0, zq, 3'h0});
			check("trim", useFactoryTrim, zq == 2'h1 || zq == 2'h2);
			for (int k = 0; k < 5; k++) begin
				if (v != 3 && k != 1)
					continue;
				u_ctl.wr(8'h0a, calCode[k], sent);
				@(negedge mclk);
				check("cal", calCmdValid, k < 4 && !(zq == 2'h1 || zq == 2'h2));
				check("calcode", calCmdCode, calCode[k]);
			end
		end
		// refresh flag set by a rate change, cleared by reading
		u_ctl.rd(8'h04, d, lat);
		check("rate", d, 8'h03);
		@(posedge mclk);
		refreshRateIn <= 3'h5;
		repeat (3) @(posedge mclk);
		u_ctl.rd(8'h04, d, lat);
		check("flag", d, 8'h85);
		u_ctl.rd(8'h04, d, lat);
		check("cleared", d, 8'h05);
		// read-only contents, write-only and reserved places still answer
		for (int k = 0; k < 8; k++) begin
			if (k < 6) begin
				u_ctl.rd(roAddr[k], d, lat);
				check("ro", d, roVal[k]);
			end
			u_ctl.rd(woAddr[k], d, lat);
			check("strobe", lat, 1);
			check("wo", d, 8'h00);
		end
		// random writes, reserved codes and read-only targets among them
		for (int k = 0; k < 60; k++) begin
			a = wrAddr[$unsigned($random(seed)) % 6];
			u_ctl.wr(a, 8'($random(seed)), sent);
			model_write(a, sent);
			@(negedge mclk);
			cmp_cfg();
		end
		// soft reset restarts auto-init and restores defaults
		u_ctl.wr(8'h3f, 8'h00, sent);
		model_write(8'h3f, sent);
		u_ctl.rd(8'h00, d, lat);
		check("busy", d[0], 1'b1);
		check("busypin", autoInitBusy, 1'b1);
		wait_init();
		check("inittime", n <= `INIT_CYCLES, 1'b1);
		u_ctl.rd(8'h00, d, lat);
		check("done", d[0], 1'b0);
		cmp_cfg();
		// burst order in every length, type and wrap mode
		for (int m = 0; m < 6; m++) begin
			u_ctl.wr(8'h01, {3'h1, bMode[m]}, sent);
			model_write(8'h01, sent);
			@(negedge mclk);
			cmp_cfg();
			repeat (3) begin
				u_ctl.burst(4'($random(seed)), expCfg.wrap_control_bit, col);
				len = 4 << (expCfg.burst_length_field - 3'h2);
				msk = expCfg.wrap_control_bit ? 4'hf : 4'(len - 1);
				for (int i = 0; i < len; i++) begin
					@(negedge mclk);
					check("active", burstActive, 1'b1);
					check("beat", beatColumn & msk, beat(expCfg, col, i) & msk);
				end
				@(negedge mclk);
				check("end", burstActive, 1'b0);
			end
		end
		wrap_up();
	end
endmodule : sdram_mode_register_file_tb_top
